// ### logic/rto_pkg.sv
// Package: register map, reset values and carriers of the radio test bank
package rto_pkg;

    // ========================================================================
    // Bus geometry
    localparam int          ADDR_W      = 20;
    localparam int          IDX_W       = 18;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    // ========================================================================
    // Register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_AND_HIGH   = 18'h0DF22;
    localparam logic [IDX_W-1:0] IDX_AND_LOW    = 18'h0DF23;
    localparam logic [IDX_W-1:0] IDX_OR_HIGH    = 18'h0DF24;
    localparam logic [IDX_W-1:0] IDX_OR_LOW     = 18'h0DF25;
    localparam logic [IDX_W-1:0] IDX_GAIN_OVR   = 18'h0DF26;
    localparam logic [IDX_W-1:0] IDX_GAIN_MODE  = 18'h0DF27;
    localparam logic [IDX_W-1:0] IDX_FSM_STATE  = 18'h0DF39;
    localparam logic [IDX_W-1:0] IDX_CONV_I     = 18'h0DF3A;
    localparam logic [IDX_W-1:0] IDX_CONV_Q     = 18'h0DF3B;
    localparam logic [IDX_W-1:0] IDX_TX_SOURCE_SELECT    = 18'h0DF3C;
    localparam logic [IDX_W-1:0] IDX_DAC_OVR    = 18'h0DF3D;

    // ========================================================================
    // Reset values
    localparam logic [7:0] AND_HIGH_RST  = 8'hFF;
    localparam logic [6:0] AND_LOW_RST   = 7'h7F;
    localparam logic [7:0] OR_HIGH_RST   = 8'h00;
    localparam logic [6:0] OR_LOW_RST    = 7'h00;
    localparam logic [6:0] GAIN_RST      = 7'h7F;
    localparam logic [1:0] MODE_AUTO     = 2'h0;
    localparam logic [2:0] SRC_RST       = 3'h0;
    localparam logic [3:0] DAC_I_HI_RST  = 4'h0;
    localparam logic [1:0] DAC_I_LO_RST  = 2'h0;
    localparam logic [5:0] DAC_Q_RST     = 6'h00;

    // ========================================================================
    // Field positions
    localparam int GAIN_EN_BIT  = 7;
    localparam int CLK_DIS_BIT  = 7;
    localparam int MODE_OVR_LSB = 2;
    localparam int SRC_LSB      = 4;
    localparam int DAC_I_LO_LSB = 6;

    // ========================================================================
    // Transmit converter source codes
    localparam logic [2:0] SRC_MODULATOR = 3'h0;
    localparam logic [2:0] SRC_OVERRIDE  = 3'h1;
    localparam logic [2:0] SRC_ADC_HIGH  = 3'h2;
    localparam logic [2:0] SRC_FILTERED  = 3'h3;
    localparam logic [2:0] SRC_NOISE     = 3'h4;
    localparam logic [2:0] SRC_ADC_LOW   = 3'h5;
    localparam logic [2:0] SRC_MAGNITUDE = 3'h6;
    localparam logic [2:0] SRC_DEBUG     = 3'h7;

    // ========================================================================
    // Carriers
    typedef struct packed {
        logic vga_reset_n;
        logic global_bias_powerdown;
        logic output_switch_bias;
        logic buffer_select;
        logic prescaler_powerdown;
        logic amp_neg_path_powerdown;
        logic amp_pos_path_powerdown;
        logic tx_dac_powerdown;
    } rto_high_ctrl_type;

    typedef struct packed {
        logic filter_cal_osc_powerdown;
        logic charge_pump_powerdown;
        logic synth_powerdown;
        logic converter_powerdown;
        logic var_gain_amp_powerdown;
        logic rx_filter_powerdown;
        logic front_end_powerdown;
    } rto_low_ctrl_type;

    typedef struct packed {
        logic [5:0] i;
        logic [5:0] q;
    } rto_dac_pair_type;

endpackage : rto_pkg

// ### logic/rto_regs.sv
// Radio test and override register bank with AXI4-Lite slave
//
// Contract
// - Low mask holds seven power-down controls in bits 6:0, reset to one.
// - Second group repeats those controls, reset zero, bit 7 reserved.
// - Upper group bit 6 is global bias power-down, one powers down.
// - Bit 5 steers output switch: one gives amplifier its external bias.
// - Bit 4 selects buffers: zero oscillator, one amplifier buffers.
// - Bits 3..0 stop prescaler, amp paths, DACs; both paths stop mixers.
// - Bit 7 drives active-low reset of the gain amplifier peak detectors.
// - Gain override enable applies manual gain, not automatic result.
// - Gain resets 0x7F; write stores override, read returns gain used.
// - Gain-mode override: 00 automatic, 01 low, 10 medium, 11 high.
// - Bits 1:0 read the gain mode in effect, automatic or forced.
// - Bits 5:0 read the frame control state; upper bits read zero.
// - Clock-disable bit stops converter clock even when converter enabled.
// - Bits 6:0 return the live in-phase converter sample.
// - Separate register returns live quadrature sample; bit 7 reads zero.
// - Codes 000..011: modulator, override, ADC high, filtered I/Q.
// - Codes 100..111: noise, ADC low bits, magnitude, high-speed debug.
// - Bits 3:0 hold upper in-phase override, reset zero, used at 001.
// - Reserved bits read zero and ignore writes.
// - Next register holds low in-phase bits 7:6, quadrature bits 5:0.
// - Upper mask register resets with its control bits at one.
//
// Added by the designer: the AXI4-Lite register port.
module rto_regs
    import rto_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_awaddr,
    input  wire logic              s_awvalid,
    output      logic              s_awready,
    input  wire logic [31:0]       s_wdata,
    input  wire logic [3:0]        s_wstrb,
    input  wire logic              s_wvalid,
    output      logic              s_wready,
    output      logic [1:0]        s_bresp,
    output      logic              s_bvalid,
    input  wire logic              s_bready,
    input  wire logic [ADDR_W-1:0] s_araddr,
    input  wire logic              s_arvalid,
    output      logic              s_arready,
    output      logic [31:0]       s_rdata,
    output      logic [1:0]        s_rresp,
    output      logic              s_rvalid,
    input  wire logic              s_rready,
    input  wire rto_high_ctrl_type ctrl_high_in,
    input  wire rto_low_ctrl_type  ctrl_low_in,
    input  wire logic [6:0]        agc_gain_in,
    input  wire logic [1:0]        agc_mode_in,
    input  wire logic [5:0]        frame_fsm_state,
    input  wire logic [6:0]        adc_i_in,
    input  wire logic [6:0]        adc_q_in,
    input  wire rto_dac_pair_type  mod_in,
    input  wire rto_dac_pair_type  filtered_in,
    input  wire rto_dac_pair_type  noise_in,
    input  wire rto_dac_pair_type  magnitude_in,
    input  wire rto_dac_pair_type  debug_in,
    output      rto_high_ctrl_type ctrl_high_out,
    output      rto_low_ctrl_type  ctrl_low_out,
    output      logic              upmix_powerdown,
    output      logic [6:0]        vga_gain,
    output      logic [1:0]        gain_mode_status,
    output      logic              adc_clk_en,
    output      rto_dac_pair_type  dac_out
);

    // ========================================================================
    // Declarations
    logic              awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0]        bresp_q, rresp_q;
    logic [31:0]       rdata_q;
    logic              aw_hold_q, w_hold_q;
    logic [IDX_W-1:0]  aw_idx_q;
    logic [7:0]        wdata_q;
    logic              wstrb0_q;
    logic [7:0]        and_high_q, or_high_q;
    logic [6:0]        and_low_q, or_low_q;
    logic              gain_en_q;
    logic [6:0]        gain_man_q;
    logic [1:0]        mode_ovr_q;
    logic              clk_dis_q;
    logic [2:0]        src_q;
    logic [3:0]        dac_i_hi_q;
    logic [1:0]        dac_i_lo_q;
    logic [5:0]        dac_q_ovr_q;
    logic [5:0]        fsm_q;
    logic [6:0]        adc_i_q, adc_q_q;
    rto_high_ctrl_type high_q;
    rto_low_ctrl_type  low_q;
    logic              upmix_q, adc_clk_q;
    logic [6:0]        gain_q;
    logic [1:0]        mode_q;
    rto_dac_pair_type  dac_q;

    // ========================================================================
    // Write channel handshake: address and data taken in either order
    wire aw_take  = s_awvalid & awready_q;
    wire w_take   = s_wvalid & wready_q;
    wire wr_fire  = aw_hold_q & w_hold_q;
    wire aw_hold_d = (aw_hold_q | aw_take) & ~wr_fire;
    wire w_hold_d  = (w_hold_q | w_take) & ~wr_fire;
    wire bvalid_d  = wr_fire | (bvalid_q & ~s_bready);
    wire ar_take   = s_arvalid & arready_q;
    wire rvalid_d  = ar_take | (rvalid_q & ~s_rready);
    wire [IDX_W-1:0] ar_idx = s_araddr[ADDR_W-1:2];

    // Register decode of the held write address
    wire wr_ok = wr_fire & wstrb0_q;
    wire we_and_high = wr_ok & (aw_idx_q == IDX_AND_HIGH);
    wire we_and_low  = wr_ok & (aw_idx_q == IDX_AND_LOW);
    wire we_or_high  = wr_ok & (aw_idx_q == IDX_OR_HIGH);
    wire we_or_low   = wr_ok & (aw_idx_q == IDX_OR_LOW);
    wire we_gain     = wr_ok & (aw_idx_q == IDX_GAIN_OVR);
    wire we_mode     = wr_ok & (aw_idx_q == IDX_GAIN_MODE);
    wire we_conv_i   = wr_ok & (aw_idx_q == IDX_CONV_I);
    wire we_tx_source_select  = wr_ok & (aw_idx_q == IDX_TX_SOURCE_SELECT);
    wire we_dac_ovr  = wr_ok & (aw_idx_q == IDX_DAC_OVR);
    wire aw_mapped   = (aw_idx_q == IDX_AND_HIGH) | (aw_idx_q == IDX_AND_LOW)
                     | (aw_idx_q == IDX_OR_HIGH) | (aw_idx_q == IDX_OR_LOW)
                     | (aw_idx_q == IDX_GAIN_OVR) | (aw_idx_q == IDX_GAIN_MODE)
                     | (aw_idx_q == IDX_FSM_STATE) | (aw_idx_q == IDX_CONV_I)
                     | (aw_idx_q == IDX_CONV_Q) | (aw_idx_q == IDX_TX_SOURCE_SELECT)
                     | (aw_idx_q == IDX_DAC_OVR);

    // Bus handshake registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
        end
        else
        begin
            aw_hold_q <= aw_hold_d;
            w_hold_q  <= w_hold_d;
            awready_q <= ~aw_hold_d & ~bvalid_d;
            wready_q  <= ~w_hold_d & ~bvalid_d;
            bvalid_q  <= bvalid_d;
            if (wr_fire)
                bresp_q <= aw_mapped ? RESP_OKAY : RESP_SLVERR;
            arready_q <= ~rvalid_d;
            rvalid_q  <= rvalid_d;
        end
    end

    // Captured write address and data lane zero
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_idx_q <= '0;
            wdata_q  <= 8'h00;
            wstrb0_q <= 1'b0;
        end
        else
        begin
            if (aw_take)
                aw_idx_q <= s_awaddr[ADDR_W-1:2];
            if (w_take)
            begin
                wdata_q  <= s_wdata[7:0];
                wstrb0_q <= s_wstrb[0];
            end
        end
    end

    // ========================================================================
    // Software registers; reserved bits are never stored
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            and_high_q  <= AND_HIGH_RST;
            and_low_q   <= AND_LOW_RST;
            or_high_q   <= OR_HIGH_RST;
            or_low_q    <= OR_LOW_RST;
            gain_en_q   <= 1'b0;
            gain_man_q  <= GAIN_RST;
            mode_ovr_q  <= MODE_AUTO;
            clk_dis_q   <= 1'b0;
            src_q       <= SRC_RST;
            dac_i_hi_q  <= DAC_I_HI_RST;
            dac_i_lo_q  <= DAC_I_LO_RST;
            dac_q_ovr_q <= DAC_Q_RST;
        end
        else
        begin
            if (we_and_high) and_high_q <= wdata_q;
            if (we_and_low)  and_low_q  <= wdata_q[6:0];
            if (we_or_high)  or_high_q  <= wdata_q;
            if (we_or_low)   or_low_q   <= wdata_q[6:0];
            if (we_gain)
            begin
                gain_en_q  <= wdata_q[GAIN_EN_BIT];
                gain_man_q <= wdata_q[6:0];
            end
            if (we_mode)    mode_ovr_q <= wdata_q[MODE_OVR_LSB +: 2];
            if (we_conv_i)  clk_dis_q  <= wdata_q[CLK_DIS_BIT];
            if (we_tx_source_select)
            begin
                src_q      <= wdata_q[SRC_LSB +: 3];
                dac_i_hi_q <= wdata_q[3:0];
            end
            if (we_dac_ovr)
            begin
                dac_i_lo_q  <= wdata_q[DAC_I_LO_LSB +: 2];
                dac_q_ovr_q <= wdata_q[5:0];
            end
        end
    end

    // ========================================================================
    // Control lines: internal value gated by the AND mask, forced by OR mask
    wire [7:0] high_d = (ctrl_high_in & and_high_q) | or_high_q;
    wire [6:0] low_d  = (ctrl_low_in & and_low_q) | or_low_q;
    wire rto_high_ctrl_type high_s = high_d;
    wire rto_low_ctrl_type  low_s  = low_d;
    // Both amplifier paths down also stop the up-conversion mixers
    wire upmix_d = high_s.amp_neg_path_powerdown
                 & high_s.amp_pos_path_powerdown;
    // Converter clock runs only when enabled and not gated
    wire adc_clk_d = ~low_s.converter_powerdown & ~clk_dis_q;
    // Gain and gain mode in effect
    wire [6:0] gain_d = gain_en_q ? gain_man_q : agc_gain_in;
    wire [1:0] mode_d = (mode_ovr_q != MODE_AUTO) ? mode_ovr_q
                                                  : agc_mode_in;

    // Transmit converter source selection
    wire rto_dac_pair_type ovr_pair = '{i: {dac_i_hi_q, dac_i_lo_q},
                                        q: dac_q_ovr_q};
    wire rto_dac_pair_type adc_hi = '{i: adc_i_q[6:1], q: adc_q_q[6:1]};
    wire rto_dac_pair_type adc_lo = '{i: adc_i_q[5:0], q: adc_q_q[5:0]};
    wire rto_dac_pair_type dac_d =
          (src_q == SRC_OVERRIDE)  ? ovr_pair
        : (src_q == SRC_ADC_HIGH)  ? adc_hi
        : (src_q == SRC_FILTERED)  ? filtered_in
        : (src_q == SRC_NOISE)     ? noise_in
        : (src_q == SRC_ADC_LOW)   ? adc_lo
        : (src_q == SRC_MAGNITUDE) ? magnitude_in
        : (src_q == SRC_DEBUG)     ? debug_in
        : mod_in;

    // Registered radio-facing outputs and live samples
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            high_q    <= AND_HIGH_RST & ~OR_HIGH_RST;
            low_q     <= AND_LOW_RST & ~OR_LOW_RST;
            upmix_q   <= 1'b0;
            adc_clk_q <= 1'b0;
            gain_q    <= GAIN_RST;
            mode_q    <= MODE_AUTO;
            dac_q     <= '0;
            fsm_q     <= 6'h00;
            adc_i_q   <= 7'h00;
            adc_q_q   <= 7'h00;
        end
        else
        begin
            high_q    <= high_s;
            low_q     <= low_s;
            upmix_q   <= upmix_d;
            adc_clk_q <= adc_clk_d;
            gain_q    <= gain_d;
            mode_q    <= mode_d;
            dac_q     <= dac_d;
            fsm_q     <= frame_fsm_state;
            adc_i_q   <= adc_i_in;
            adc_q_q   <= adc_q_in;
        end
    end

    // ========================================================================
    // Read data selection; reserved bits and unmapped words read zero
    wire [7:0] rd_byte =
          (ar_idx == IDX_AND_HIGH)  ? and_high_q
        : (ar_idx == IDX_AND_LOW)   ? {1'b0, and_low_q}
        : (ar_idx == IDX_OR_HIGH)   ? or_high_q
        : (ar_idx == IDX_OR_LOW)    ? {1'b0, or_low_q}
        : (ar_idx == IDX_GAIN_OVR)  ? {gain_en_q, gain_q}
        : (ar_idx == IDX_GAIN_MODE) ? {4'h0, mode_ovr_q, mode_q}
        : (ar_idx == IDX_FSM_STATE) ? {2'h0, fsm_q}
        : (ar_idx == IDX_CONV_I)    ? {clk_dis_q, adc_i_q}
        : (ar_idx == IDX_CONV_Q)    ? {1'b0, adc_q_q}
        : (ar_idx == IDX_TX_SOURCE_SELECT)   ? {1'b0, src_q, dac_i_hi_q}
        : (ar_idx == IDX_DAC_OVR)   ? {dac_i_lo_q, dac_q_ovr_q}
        : 8'h00;
    wire ar_mapped = (ar_idx == IDX_AND_HIGH) | (ar_idx == IDX_AND_LOW)
                   | (ar_idx == IDX_OR_HIGH) | (ar_idx == IDX_OR_LOW)
                   | (ar_idx == IDX_GAIN_OVR) | (ar_idx == IDX_GAIN_MODE)
                   | (ar_idx == IDX_FSM_STATE) | (ar_idx == IDX_CONV_I)
                   | (ar_idx == IDX_CONV_Q) | (ar_idx == IDX_TX_SOURCE_SELECT)
                   | (ar_idx == IDX_DAC_OVR);

    // Read answer capture
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end
        else if (ar_take)
        begin
            rdata_q <= {24'h00_0000, rd_byte};
            rresp_q <= ar_mapped ? RESP_OKAY : RESP_SLVERR;
        end
    end

    // ========================================================================
    // Port drive
    assign s_awready        = awready_q;
    assign s_wready         = wready_q;
    assign s_bvalid         = bvalid_q;
    assign s_bresp          = bresp_q;
    assign s_arready        = arready_q;
    assign s_rvalid         = rvalid_q;
    assign s_rdata          = rdata_q;
    assign s_rresp          = rresp_q;
    assign ctrl_high_out    = high_q;
    assign ctrl_low_out     = low_q;
    assign upmix_powerdown  = upmix_q;
    assign vga_gain         = gain_q;
    assign gain_mode_status = mode_q;
    assign adc_clk_en       = adc_clk_q;
    assign dac_out          = dac_q;

    // ========================================================================
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_both_paths_down;
        high_s.amp_neg_path_powerdown && high_s.amp_pos_path_powerdown;
    endsequence

    a_mask_combine: assert property (
        aresetn |=> ctrl_low_out
            == $past((ctrl_low_in & and_low_q) | or_low_q))
        else $error("Low control line not AND then OR of masks");
    a_high_combine: assert property (
        aresetn |=> ctrl_high_out
            == $past((ctrl_high_in & and_high_q) | or_high_q))
        else $error("High control line not AND then OR of masks");
    a_upmix_follow: assert property (
        aresetn ##0 s_both_paths_down |=> upmix_powerdown)
        else $error("Mixers not powered down with both amp paths");
    a_gain_override: assert property (
        gain_en_q |=> vga_gain == $past(gain_man_q))
        else $error("Manual gain not applied under override");
    a_gain_auto: assert property (
        aresetn && !gain_en_q |=> vga_gain == $past(agc_gain_in))
        else $error("Automatic gain not used without override");
    a_mode_force: assert property (
        mode_ovr_q != MODE_AUTO |=> gain_mode_status == $past(mode_ovr_q))
        else $error("Forced gain mode not in effect");
    a_adc_clk_gate: assert property (
        clk_dis_q |=> !adc_clk_en)
        else $error("Converter clock runs while disabled");
    a_src_override: assert property (
        src_q == SRC_OVERRIDE |=> dac_out == $past(ovr_pair))
        else $error("Override values not routed to converter");
    a_rsvd_zero: assert property (
        rvalid_q |-> s_rdata[31:8] == 24'h00_0000)
        else $error("Reserved read bits not zero");
    a_write_answer: assert property (
        wr_fire |=> s_bvalid ##0 !s_awready[*1])
        else $error("Write response missing after both channels");

endmodule : rto_regs

// ### bench/rto_regs_test.sv
// Testbench: radio test register bank driven over AXI4-Lite
module rto_regs_test
    import rto_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================================================
    // Signals named as the design's ports
    logic              aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready;
    logic              s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid;
    logic              s_rready, upmix_powerdown, adc_clk_en;
    logic [ADDR_W-1:0] s_awaddr, s_araddr;
    logic [31:0]       s_wdata, s_rdata, rd;
    logic [3:0]        s_wstrb;
    logic [1:0]        s_bresp, s_rresp, agc_mode_in, gain_mode_status, rsp, e;
    logic [6:0]        agc_gain_in, adc_i_in, adc_q_in, vga_gain;
    logic [5:0]        frame_fsm_state;
    logic [7:0]        a, o, h;
    logic [15:0]       lf = 16'hCE3C;
    int                error_cnt = 0, check_count = 0;
    rto_high_ctrl_type ctrl_high_in, ctrl_high_out;
    rto_low_ctrl_type  ctrl_low_in, ctrl_low_out;
    rto_dac_pair_type  mod_in, filtered_in, noise_in, magnitude_in, debug_in;
    rto_dac_pair_type  dac_out;
    rto_regs DUT (.*);
    // ========================================================================
    // Helpers
    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nxt
    function automatic rto_dac_pair_type exp_dac(input logic [2:0] c);
        case (c)
            3'h0: return mod_in;
            3'h1: return {h[3:0], o};
            3'h2: return {adc_i_in[6:1], adc_q_in[6:1]};
            3'h3: return filtered_in;
            3'h4: return noise_in;
            3'h5: return {adc_i_in[5:0], adc_q_in[5:0]};
            3'h6: return magnitude_in;
            default: return debug_in;
        endcase
    endfunction : exp_dac
    task automatic rnd();
        lf = nxt(lf); ctrl_high_in <= lf[7:0]; ctrl_low_in <= lf[14:8];
        lf = nxt(lf); agc_gain_in <= lf[6:0]; agc_mode_in <= lf[8:7];
        frame_fsm_state <= lf[14:9];
        lf = nxt(lf); adc_i_in <= lf[6:0]; adc_q_in <= lf[13:7];
        mod_in <= lf[11:0]; filtered_in <= ~lf[11:0];
        lf = nxt(lf); noise_in <= lf[11:0]; debug_in <= lf[15:4];
        magnitude_in <= {lf[5:0], lf[11:6]};
    endtask : rnd
    task automatic chk(input logic [39:0] g, input logic [39:0] x);
        check_count++;
        if (g !== x)
        begin
            $display("unexpected at %0t: got %h expected %h", $time, g, x);
            error_cnt++;
        end
    endtask : chk
    // Write one register; response lands in rsp
    task automatic wr(input logic [IDX_W-1:0] x, input logic [7:0] d);
        @(posedge aclk);
        s_awaddr <= {x, 2'h0}; s_wdata <= {24'h0, d};
        s_awvalid <= 1'b1; s_wvalid <= 1'b1; s_bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_awvalid && s_awready) s_awvalid <= 1'b0;
            if (s_wvalid && s_wready) s_wvalid <= 1'b0;
        end while (!s_bvalid);
        rsp = s_bresp; s_bready <= 1'b0;
    endtask : wr
    // Read one register into rd and rsp
    task automatic rdr(input logic [IDX_W-1:0] x);
        @(posedge aclk);
        s_araddr <= {x, 2'h0}; s_arvalid <= 1'b1; s_rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_arvalid && s_arready) s_arvalid <= 1'b0;
        end while (!s_rvalid);
        rd = s_rdata; rsp = s_rresp; s_rready <= 1'b0;
    endtask : rdr
    task automatic rc(input logic [IDX_W-1:0] x, input logic [7:0] v);
        rdr(x);
        chk({rsp, rd}, {RESP_OKAY, 24'h0, v});
    endtask : rc
    task automatic summarize();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : summarize
    // ========================================================================
    // Clock, watchdog and main sequence
    initial
    begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    initial
    begin
        #200000;
        error_cnt++;
        summarize();
    end
    initial
    begin
        aresetn <= 1'b0; s_awvalid <= 1'b0; s_wvalid <= 1'b0; s_bready <= 1'b0;
        s_arvalid <= 1'b0; s_rready <= 1'b0; s_wstrb <= 4'h1;
        s_awaddr <= '0; s_araddr <= '0; s_wdata <= '0;
        rnd();
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rc(IDX_AND_HIGH, AND_HIGH_RST);
        rc(IDX_AND_LOW, {1'b0, AND_LOW_RST});
        rc(IDX_OR_LOW, {1'b0, OR_LOW_RST});
        rc(IDX_TX_SOURCE_SELECT, 8'h00);
        rc(IDX_DAC_OVR, 8'h00);
        wr(IDX_AND_LOW, 8'hFF);
        rc(IDX_AND_LOW, 8'h7F);
        // Fixed masks on the first pass, then random masks, against random internal controls
        for (int i = 0; i < 6; i++)
        begin
            lf = nxt(lf); a = (i == 0) ? 8'h00 : lf[7:0];
            o = (i == 0) ? 8'h06 : lf[15:8] & 8'h5A;
            wr(IDX_AND_HIGH, a); wr(IDX_OR_HIGH, o);
            wr(IDX_AND_LOW, a); wr(IDX_OR_LOW, o);
            @(posedge aclk); rnd(); repeat (3) @(posedge aclk);
            chk(ctrl_high_out, (ctrl_high_in & a) | o);
            chk(ctrl_low_out, (ctrl_low_in & a[6:0]) | o[6:0]);
            chk(upmix_powerdown, &ctrl_high_out[2:1]);
            chk(adc_clk_en, !ctrl_low_out[3]);
        end
        wr(IDX_AND_LOW, 8'h7F); wr(IDX_OR_LOW, 8'h00);
        wr(IDX_CONV_I, 8'h80); repeat (2) @(posedge aclk);
        chk(adc_clk_en, 1'b0);
        rc(IDX_CONV_I, {1'b1, adc_i_in});
        rc(IDX_CONV_Q, {1'b0, adc_q_in});
        rc(IDX_FSM_STATE, {2'h0, frame_fsm_state});
        rc(IDX_GAIN_OVR, {1'b0, agc_gain_in});
        wr(IDX_GAIN_OVR, {1'b1, ~agc_gain_in}); repeat (2) @(posedge aclk);
        chk(vga_gain, 7'(~agc_gain_in));
        rc(IDX_GAIN_OVR, {1'b1, ~agc_gain_in});
        for (int m = 0; m < 4; m++)
        begin
            wr(IDX_GAIN_MODE, 8'(m << 2)); repeat (2) @(posedge aclk);
            e = (m == 0) ? agc_mode_in : 2'(m);
            chk(gain_mode_status, e);
            rc(IDX_GAIN_MODE, {4'h0, 2'(m), e});
        end
        wr(IDX_AND_HIGH, 8'hFE); wr(IDX_OR_HIGH, 8'h00);
        repeat (2) @(posedge aclk);
        chk(ctrl_high_out[0], 1'b0);
        lf = nxt(lf); o = lf[7:0]; h = lf[15:8];
        wr(IDX_DAC_OVR, o);
        for (int c = 0; c < 8; c++)
        begin
            wr(IDX_TX_SOURCE_SELECT, {1'b0, 3'(c), h[3:0]}); repeat (2) @(posedge aclk);
            chk(dac_out, exp_dac(3'(c)));
        end
        // Lane zero strobe low leaves the register untouched
        s_wstrb <= 4'h0; wr(IDX_OR_HIGH, 8'hFF); s_wstrb <= 4'h1;
        rc(IDX_OR_HIGH, 8'h00);
        rdr(18'h0DF30); chk(rsp, RESP_SLVERR);
        wr(18'h0DF30, 8'h55); chk(rsp, RESP_SLVERR);
        summarize();
    end
endmodule : rto_regs_test
